// ===== rx_rail_pkg.sv
package rx_rail_pkg;

	// ----------------------------------------------------------------
	// Line rates
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_DS3,
		RATE_STS1,
		RATE_E3
	} line_rate_t;

	// ----------------------------------------------------------------
	// Reference and synthesis
	// ----------------------------------------------------------------
	// Frequencies in kHz
	localparam int REF_SFM_KHZ = 12288;
	localparam int E3_KHZ = 34368;
	localparam int DS3_KHZ = 44736;
	localparam int STS1_KHZ = 51840;
	// Phase accumulator width for the digital synthesizer model
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
	// Output toggles every half period, so the step is doubled
	localparam logic [ACC_W-1:0] STEP_E3 =
		ACC_W'(64'd2 * E3_KHZ * (64'd1 << ACC_W) / (64'd4 * REF_SFM_KHZ * 4));
	localparam logic [ACC_W-1:0] STEP_DS3 =
		ACC_W'(64'd2 * DS3_KHZ * (64'd1 << ACC_W) / (64'd4 * REF_SFM_KHZ * 4));
	localparam logic [ACC_W-1:0] STEP_STS1 =
		ACC_W'(64'd2 * STS1_KHZ * (64'd1 << ACC_W) / (64'd4 * REF_SFM_KHZ * 4));

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 8;
	localparam logic RESET_LOW = 1'b0;

	typedef struct packed {
		logic pos;
		logic neg;
		logic violation;
	} rx_sym_t;

	typedef struct packed {
		logic host_mode;
		logic single_rail;
		logic monitor;
		line_rate_t rate;
		logic sfm;
	} cfg_t;

endpackage

// ===== rx_sym_fifo.sv
`timescale 1ns/100ps
module rx_sym_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_st_t;

	fifo_st_t s_q;
	fifo_st_t s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic push;
	logic pop;

	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[s_q.rd];

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr = AW'(s_q.wr + 1'b1);
		end
		if (pop) begin
			s_d.rd = AW'(s_q.rd + 1'b1);
		end
		if (push && !pop) begin
			s_d.cnt = (AW+1)'(s_q.cnt + 1'b1);
		end else if (pop && !push) begin
			s_d.cnt = (AW+1)'(s_q.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Storage has no reset; an entry is only popped after it has been written
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[s_q.wr] <= in_data;
		end
	end
endmodule

// ===== rx_rail_output_and_refclk_select.sv
`timescale 1ns/100ps
module rx_rail_output_and_refclk_select (
	input wire logic clk,
	input wire logic reset,
	// Straps and mode pins, asynchronous to clk
	input wire logic host_or_strap_select,
	input wire logic rail_mode_select,
	input wire logic rx_monitor_select_in,
	input wire logic e3_select,
	input wire logic sonet_or_t3_select,
	input wire logic single_freq_enable,
	// Host register bits, same domain
	input wire logic host_single_rail,
	input wire logic host_monitor,
	input wire logic [1:0] host_rate,
	// Host serial data shares the monitor pin
	input wire logic host_serial_data,
	output logic host_serial_out,
	output logic host_serial_out_oe,
	// Recovered symbols from the clock recovery stage
	input wire logic sym_valid,
	input wire logic sym_pos,
	input wire logic sym_neg,
	input wire logic sym_code_violation,
	output logic sym_ready,
	// Reference clock input, sampled as data
	input wire logic reference_clock_in,
	// Outputs to the framer
	output logic recovered_rx_clock,
	output logic rx_positive_data_out,
	output logic rx_negative_data_out,
	output logic codec_enable,
	output logic monitor_mode,
	output logic clock_out,
	output logic [1:0] line_rate
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		// Strap order, msb first: host, rail, monitor, e3, sonet, sfm
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic ref1;
		logic ref2;
		logic ref_prev;
		rx_rail_pkg::cfg_t cfg;
		logic rec_clk;
		logic pos;
		logic neg;
		logic [rx_rail_pkg::ACC_W-1:0] acc;
		logic clkout;
	} state_t;

	state_t s_q;
	state_t s_d;

	rx_rail_pkg::rx_sym_t fifo_in;
	rx_rail_pkg::rx_sym_t fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic [rx_rail_pkg::ACC_W-1:0] step;
	logic [rx_rail_pkg::ACC_W:0] acc_sum;

	assign fifo_in = '{pos: sym_pos, neg: sym_neg,
		violation: sym_code_violation};

	// ----------------------------------------------------------------
	// Symbol buffer between recovery and output pins
	// ----------------------------------------------------------------
	rx_sym_fifo #(
		.WIDTH($bits(rx_rail_pkg::rx_sym_t)),
		.DEPTH(rx_rail_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_data(fifo_in),
		.in_valid(sym_valid),
		.in_ready(sym_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// One symbol per recovered clock period, taken as the clock goes low so
	// the next rising edge presents it; an empty buffer emits idle zeros.
	assign fifo_pop = s_q.rec_clk;

	// ----------------------------------------------------------------
	// Synthesizer step per line rate
	// ----------------------------------------------------------------
	always_comb begin
		case (s_q.cfg.rate)
		rx_rail_pkg::RATE_E3: begin
			step = rx_rail_pkg::STEP_E3;
		end
		rx_rail_pkg::RATE_STS1: begin
			step = rx_rail_pkg::STEP_STS1;
		end
		default: begin
			step = rx_rail_pkg::STEP_DS3;
		end
		endcase
	end

	assign acc_sum = {1'b0, s_q.acc} + {1'b0, step};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Straps are asynchronous: two stages before anything decodes them
		s_d.sync1 = {host_or_strap_select, rail_mode_select,
			rx_monitor_select_in, e3_select, sonet_or_t3_select,
			single_freq_enable};
		s_d.sync2 = s_q.sync1;
		s_d.ref1 = reference_clock_in;
		s_d.ref2 = s_q.ref1;
		s_d.ref_prev = s_q.ref2;

		// Host mode ignores every strap except the single-frequency enable
		s_d.cfg.host_mode = s_q.sync2[5];
		s_d.cfg.sfm = s_q.sync2[0];
		if (s_q.sync2[5]) begin
			s_d.cfg.single_rail = host_single_rail;
			s_d.cfg.monitor = host_monitor;
			// Host rate code: 2 is E3, 1 is STS-1, anything else DS3
			case (host_rate)
			2'd2: s_d.cfg.rate = rx_rail_pkg::RATE_E3;
			2'd1: s_d.cfg.rate = rx_rail_pkg::RATE_STS1;
			default: s_d.cfg.rate = rx_rail_pkg::RATE_DS3;
			endcase
		end else begin
			s_d.cfg.single_rail = s_q.sync2[4];
			s_d.cfg.monitor = s_q.sync2[3];
			if (s_q.sync2[2]) begin
				s_d.cfg.rate = rx_rail_pkg::RATE_E3;
			end else if (s_q.sync2[1]) begin
				s_d.cfg.rate = rx_rail_pkg::RATE_STS1;
			end else begin
				s_d.cfg.rate = rx_rail_pkg::RATE_DS3;
			end
		end

		// Recovered clock at half the system clock
		s_d.rec_clk = !s_q.rec_clk;
		if (s_q.rec_clk) begin
			// Data change as the recovered clock falls, stable across its rise
			if (fifo_valid) begin
				s_d.pos = fifo_out.pos;
				if (s_q.cfg.single_rail) begin
					s_d.neg = fifo_out.violation;
				end else begin
					s_d.neg = fifo_out.neg;
				end
			end else begin
				s_d.pos = 1'b0;
				s_d.neg = 1'b0;
			end
		end

		// The accumulator advances once per sampled reference rising edge, so the
		// output jitter is bounded by one reference period; a true PLL
		// would smooth this but is outside the digital domain.
		if (s_q.cfg.sfm) begin
			if (s_q.ref2 && !s_q.ref_prev) begin
				s_d.acc = acc_sum[rx_rail_pkg::ACC_W-1:0];
				if (acc_sum[rx_rail_pkg::ACC_W]) begin
					s_d.clkout = !s_q.clkout;
				end
			end
		end else begin
			s_d.acc = rx_rail_pkg::ACC_RESET;
			s_d.clkout = rx_rail_pkg::RESET_LOW;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset clears all state, so every output except host_serial_out and sym_ready, including the pin enable, starts low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign recovered_rx_clock = s_q.rec_clk;
	assign rx_positive_data_out = s_q.pos;
	assign rx_negative_data_out = s_q.neg;
	assign codec_enable = s_q.cfg.single_rail;
	assign monitor_mode = s_q.cfg.monitor;
	assign clock_out = s_q.clkout;
	assign line_rate = s_q.cfg.rate;
	// Straight copy; only the enable decides whether the pin is driven
	assign host_serial_out = host_serial_data;
	assign host_serial_out_oe = s_q.cfg.host_mode;
endmodule

// ===== rx_rail_asserts.sv
`timescale 1ns/100ps
module rx_rail_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic host_or_strap_select,
	input wire logic rail_mode_select,
	input wire logic e3_select,
	input wire logic single_freq_enable,
	input wire logic host_single_rail,
	input wire logic [1:0] host_rate,
	input wire logic host_serial_data,
	input wire logic host_serial_out,
	input wire logic host_serial_out_oe,
	input wire logic recovered_rx_clock,
	input wire logic rx_negative_data_out,
	input wire logic codec_enable,
	input wire logic clock_out,
	input wire logic [1:0] line_rate
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// Receive output timing
	// ----------------------------------------------------------------
	a_recovered_rx_clock_toggles: assert property (
		!$past(reset) |-> recovered_rx_clock != $past(recovered_rx_clock))
		else $error("recovered clock did not toggle");
	a_neg_at_fall: assert property (
		!$stable(rx_negative_data_out) |-> $fell(recovered_rx_clock))
		else $error("negative data moved off the update edge");
	a_neg_holds: assert property (
		$fell(recovered_rx_clock) |=> $stable(rx_negative_data_out))
		else $error("negative data shorter than one period");
	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	// Straps cross two sync stages and a config register, so 4 edges
	a_oe_host: assert property (
		host_or_strap_select[*4] |-> host_serial_out_oe)
		else $error("serial out not driven in host mode");
	a_serial_copy: assert property (
		host_serial_out_oe |-> host_serial_out == host_serial_data)
		else $error("serial out differs from serial data");
	a_strap_rail: assert property (
		(!host_or_strap_select && $stable(rail_mode_select))[*4]
		|-> codec_enable == rail_mode_select)
		else $error("codec enable ignores rail strap");
	a_host_rail: assert property (
		(host_or_strap_select && $stable(host_single_rail))[*4]
		|-> codec_enable == host_single_rail)
		else $error("codec enable ignores host rail bit");
	a_strap_rate: assert property (
		(!host_or_strap_select && e3_select)[*4] |-> line_rate == 2'h2)
		else $error("rate strap high did not give E3");
	a_host_rate: assert property (
		(host_or_strap_select && host_rate == 2'h1)[*4] |-> line_rate == 2'h1)
		else $error("host rate bits not followed");
	a_sfm_quiet: assert property (
		!single_freq_enable[*6] |-> !clock_out)
		else $error("clock out active without single frequency");
	cover property ($rose(codec_enable));
	cover property ($rose(clock_out));
	cover property ($rose(host_serial_out_oe));
endmodule
bind rx_rail_output_and_refclk_select rx_rail_asserts rx_rail_asserts_inst (
	.clk, .reset, .host_or_strap_select, .rail_mode_select, .e3_select,
	.single_freq_enable, .host_single_rail, .host_rate, .host_serial_data,
	.host_serial_out, .host_serial_out_oe, .recovered_rx_clock,
	.rx_negative_data_out, .codec_enable, .clock_out, .line_rate);

// ===== frame_sink.sv
`timescale 1ns/100ps
module frame_sink (
	input wire logic clk,
	input wire logic reset,
	input wire logic rx_clk,
	input wire logic pos,
	input wire logic neg,
	output logic [1:0] got,
	output logic got_v
);
	logic rx_clk_q;
	// Samples one clk after the recovered clock rises, at its falling edge, taking the symbol held across that rise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_clk_q <= 1'h0;
			got_v <= 1'h0;
			got <= 2'h0;
		end else begin
			rx_clk_q <= rx_clk;
			got_v <= rx_clk && !rx_clk_q;
			got <= {pos, neg};
		end
	end
endmodule

// ===== rx_rail_output_and_refclk_select_tb.sv
`timescale 1ns/100ps
module rx_rail_output_and_refclk_select_tb;
	logic clk, reset, host, rail, mon, e3, sonet, sfm, hsr, hmon, hsd, refclk;
	logic v, p, n, l, rdy, sso, oe, rxc, rp, rn, cen, mm, co, gv;
	logic [1:0] hrate, rate, got;
	logic [1:0] smp[$], exq[$];
	int n_fail = 0, checked = 0, cyc = 0, ce, cd, cs, cz;
	always #5 clk = ~clk;
	always #41 refclk = ~refclk;
	rx_rail_output_and_refclk_select rx_rail_output_and_refclk_select_inst (
		.clk(clk), .reset(reset), .host_or_strap_select(host),
		.rail_mode_select(rail), .rx_monitor_select_in(mon), .e3_select(e3),
		.sonet_or_t3_select(sonet), .single_freq_enable(sfm),
		.host_single_rail(hsr), .host_monitor(hmon), .host_rate(hrate),
		.host_serial_data(hsd), .host_serial_out(sso),
		.host_serial_out_oe(oe), .sym_valid(v), .sym_pos(p), .sym_neg(n),
		.sym_code_violation(l), .sym_ready(rdy),
		.reference_clock_in(refclk),
		.recovered_rx_clock(rxc), .rx_positive_data_out(rp),
		.rx_negative_data_out(rn), .codec_enable(cen), .monitor_mode(mm),
		.clock_out(co), .line_rate(rate));
	frame_sink frame_sink_inst (.clk(clk), .reset(reset), .rx_clk(rxc),
		.pos(rp), .neg(rn), .got(got), .got_v(gv));
	always @(posedge clk) if (gv) smp.push_back(got);
	task automatic summarize();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Ceiling: bursts and config take about 500 cycles, clock counts 8000
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	function automatic logic [1:0] exp_rate(logic [10:0] c);
		if (c[10]) return c[2:1] == 2'h2 ? 2'h2 : {1'h0, c[2:1] == 2'h1};
		return c[7] ? 2'h2 : {1'h0, c[6]};
	endfunction
	// Bit order: host rail mon e3 sonet sfm hsr hmon hrate hsd
	task automatic cfg(logic [10:0] c);
		{host, rail, mon, e3, sonet, sfm, hsr, hmon, hrate, hsd} = c;
		step(4);
		chk(8'(cen), 8'(host ? hsr : rail));
		chk(8'(mm), 8'(host ? hmon : mon));
		chk(8'(rate), 8'(exp_rate(c)));
		chk(8'({oe, sso}), 8'({host, hsd}));
	endtask
	// Valid stays up between pushes; only the burst end drops it
	// Ready is read before the edge, so it is the one that edge sees
	task automatic push(logic [2:0] s);
		int t;
		logic r;
		t = 0;
		{p, n, l} = s;
		v = 1'h1;
		do begin
			r = rdy;
			@(posedge clk);
			t++;
		end while (r !== 1'h1 && t < 100);
		if (r !== 1'h1) n_fail++;
		#1;
	endtask
	task automatic burst(logic sr);
		logic [2:0] s;
		exq = {};
		smp = {};
		push(3'h7);
		exq.push_back(2'h3);
		repeat (19) begin
			s = 3'($urandom);
			push(s);
			exq.push_back({s[2], sr ? s[0] : s[1]});
		end
		v = 1'h0;
		step(60);
		while (smp.size() > 0 && smp[0] !== 2'h3) void'(smp.pop_front());
		foreach (exq[i]) chk(8'(smp[i]), 8'(exq[i]));
	endtask
	task automatic count(logic [1:0] r, logic f, output int c);
		logic q;
		cfg({1'h1, 4'h0, f, 2'h0, r, 1'h0});
		c = 0;
		q = co;
		repeat (2000) begin
			@(posedge clk);
			if (co === 1'h1 && q === 1'h0) c++;
			q = co;
		end
		#1;
	endtask
	initial begin
		{clk, host, rail, mon, e3, sonet, sfm, hsr, hmon, hsd} = 10'h0;
		{refclk, v, p, n, l} = 5'h0;
		hrate = 2'h0;
		reset = 1'h1;
		void'($urandom(43));
		step(3);
		reset = 1'h0;
		for (int i = 0; i < 4; i++) begin
			cfg({i[1], i[0], 4'h0, i[0], 4'h0});
			burst(i[0]);
			$display("test rail %0d done", i);
		end
		cfg(11'h400);
		cfg(11'h080);
		cfg(11'h040);
		cfg(11'h0c0);
		repeat (16) cfg(11'($urandom));
		$display("test config done");
		count(2'h2, 1'h1, ce);
		count(2'h0, 1'h1, cd);
		count(2'h1, 1'h1, cs);
		count(2'h2, 1'h0, cz);
		chk(8'(ce > 0 && ce < cd && cd < cs), 8'h1);
		chk(8'(cz != 0), 8'h0);
		$display("test clock out done");
		summarize();
	end
endmodule
